// [logic/ptr_reader_ctrl.sv]
// Purpose: Paper tape reader control: command decode, buffer, flags.
// Assumes: Command inputs are one-cycle pulses already device-decoded.
// Notes:   Sampled lines pass through a FIFO before assembly.
`timescale 1ns/10ps
`include "ptr_defs.svh"
// Summary of operation
// - Binary select reads three lines of six bits into one 18-bit word.
// - First binary line lands in buffer bits 12 to 17.
// - Second line moves bits 12-17 to 6-11 and loads 12-17.
// - Third line shifts 6-11 to 0-5, 12-17 to 6-11, loads 12-17.
// - Full three-line word sets the ready flag.
// - Binary mode ignores holes 7 and 8; lines need hole 8.
// - Alphanumeric select clears flag, reads one 8-bit line, sets flag.
// - Binary select clears flag at once, sets it after assembly.
// - Skip test answers skip while ready flag is set.
// - Clear-flag command clears flag and ORs buffer onto accumulator.
// - Read-buffer command clears flag, clears accumulator, loads buffer.
// - Alphanumeric line loads buffer bits 10 to 17 only.
// - Power clear, begin pulse or clear command reset run, flag, and mode unless read-in is held.
// - Select start clears buffer, flag, line counts and sets run.
// - Start sets binary mode from instruction bit 5; read-in forces it.
// - Feed hole while running fires delay before sampling.
// - Alphanumeric strobe loads whole line and sets ready flag.
// - Binary mode suppresses hole 7/8 strobe; shifts need hole 8.
// - Two line-count flops track lines; third line sets flag.
// - Rising ready flag clears run, and mode unless read-in is held, stopping the reader.
module ptr_reader_ctrl
  import ptr_pkg::*;
#(
  parameter int SAMPLE_DLY_CYC = `PTR_SAMPLE_DLY_CYC,
  parameter int FIFO_DEPTH     = `PTR_FIFO_DEPTH
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_i,
  input  wire logic                power_on_clear_i,
  input  wire logic                manual_begin_pulse_i,
  input  wire logic                manual_readin_i,
  input  wire ptr_pkg::ptr_instr_t instruction_holding_reg_i,
  input  wire logic                skip_on_ready_cmd_i,
  input  wire logic                clear_flag_or_cmd_i,
  input  wire logic                select_cmd_i,
  input  wire logic                feed_hole_i,
  input  wire ptr_pkg::ptr_line_t  tape_line_i,
  output logic                     tape_line_ready_o,
  output logic                     skip_o,
  output logic                     ready_flag_o,
  output logic                     reader_run_o,
  output logic                     binary_mode_o,
  output ptr_pkg::ptr_word_t       ac_data_o,
  output logic                     ac_or_o,
  output logic                     ac_clear_o
);
  import ptr_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  ptr_word_t tape_word_buffer_q;
  ptr_word_t buf_d;
  logic      flag_q;
  logic      flag_prev_q;
  logic      run_q;
  logic      mode_q;
  logic      first_line_seen_ff_q;
  logic      second_line_seen_ff_q;
  ptr_word_t ac_data_q;
  logic      ac_or_q;
  logic      ac_clear_q;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  // Clear sources share one term; they all act the same on flag, run, mode and FIFO
  wire clr_any_w = power_on_clear_i || manual_begin_pulse_i
                   || clear_flag_or_cmd_i;
  wire start_w   = select_cmd_i;
  wire bin_sel_w = instruction_holding_reg_i[`PTR_MB_BIN_BIT];
  wire rrb_w     = clear_flag_or_cmd_i
                   && instruction_holding_reg_i[`PTR_MB_RRB_BIT];
  wire flag_rise_w = flag_q && !flag_prev_q;

  // ****************************************************************
  // Feed-hole delay and line FIFO
  // ****************************************************************
  logic      delayed_sample_pulse;
  logic      fifo_out_valid;
  ptr_line_t fifo_out_data;
  logic      fifo_out_ready;

  ptr_sample_delay #(
    .CYC (SAMPLE_DLY_CYC)
  ) u_delay (
    .ref_clk_i              (ref_clk_i),
    .rst_i                  (rst_i),
    .feed_hole_i            (feed_hole_i),
    .run_i                  (run_q),
    .delayed_sample_pulse_o (delayed_sample_pulse)
  );

  // Flush on start and clear so stale lines never reach a new word
  ptr_fifo #(
    .W     (`PTR_LINE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .rst_i       (rst_i),
    .flush_i     (start_w || clr_any_w),
    .in_valid_i  (delayed_sample_pulse),
    .in_data_i   (tape_line_i),
    .in_ready_o  (tape_line_ready_o),
    .out_valid_o (fifo_out_valid),
    .out_data_o  (fifo_out_data),
    .out_ready_i (fifo_out_ready)
  );

  // ****************************************************************
  // Strobe generation
  // ****************************************************************
  // Drain stalls while a finished word waits; lines queue meanwhile
  assign fifo_out_ready = !flag_q && !start_w;
  wire pop_w       = fifo_out_valid && fifo_out_ready;
  wire hole8_w     = fifo_out_data[`PTR_HOLE8_BIT];
  wire hole78_strobe = pop_w && !mode_q;
  wire pop_bin_w   = pop_w && mode_q && hole8_w;
  wire third_w     = pop_bin_w && second_line_seen_ff_q;
  wire flag_set_w  = hole78_strobe || third_w;

  // ****************************************************************
  // Buffer input gating
  // ****************************************************************
  // Holes 7 and 8 never reach the word in binary mode
  always_comb begin
    buf_d = tape_word_buffer_q;
    if (start_w) begin
      buf_d = `PTR_WORD_RST;
    end else if (hole78_strobe) begin
      buf_d[10:17] = fifo_out_data;
    end else if (third_w) begin
      buf_d = {tape_word_buffer_q[6:11], tape_word_buffer_q[12:17],
               fifo_out_data[`PTR_SEG_W-1:0]};
    end else if (pop_bin_w && first_line_seen_ff_q) begin
      buf_d = {tape_word_buffer_q[0:5], tape_word_buffer_q[12:17],
               fifo_out_data[`PTR_SEG_W-1:0]};
    end else if (pop_bin_w) begin
      buf_d[12:17] = fifo_out_data[`PTR_SEG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) tape_word_buffer_q <= `PTR_WORD_RST;
    else       tape_word_buffer_q <= buf_d;
  end

  // ****************************************************************
  // Line counters
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || start_w) begin
      first_line_seen_ff_q  <= 1'b0;
      second_line_seen_ff_q <= 1'b0;
    end else if (pop_bin_w) begin
      first_line_seen_ff_q <= 1'b1;
      if (first_line_seen_ff_q) second_line_seen_ff_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Ready flag
  // ****************************************************************
  // Set wins over clear so a completing line is never lost
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flag_q      <= 1'b0;
      flag_prev_q <= 1'b0;
    end else begin
      flag_prev_q <= flag_q;
      if (flag_set_w)                flag_q <= 1'b1;
      else if (start_w || clr_any_w) flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Run and mode
  // ****************************************************************
  // A new select outranks the stop from the previous word
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
    end else if (start_w) begin
      run_q <= 1'b1;
    end else if (clr_any_w || flag_rise_w) begin
      run_q <= 1'b0;
    end
  end

  // Read-in holds binary mode for as long as it is asserted
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_q <= 1'b0;
    end else if (start_w) begin
      mode_q <= bin_sel_w || manual_readin_i;
    end else if (manual_readin_i) begin
      mode_q <= 1'b1;
    end else if (clr_any_w || flag_rise_w) begin
      mode_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Processor transfer
  // ****************************************************************
  // Buffer drives the collector only during the transfer pulse
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ac_data_q  <= `PTR_WORD_RST;
      ac_or_q    <= 1'b0;
      ac_clear_q <= 1'b0;
    end else begin
      ac_or_q    <= clear_flag_or_cmd_i;
      ac_clear_q <= rrb_w;
      ac_data_q  <= clear_flag_or_cmd_i ? tape_word_buffer_q
                                        : `PTR_WORD_RST;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign skip_o        = skip_on_ready_cmd_i && flag_q;
  assign ready_flag_o  = flag_q;
  assign reader_run_o  = run_q;
  assign binary_mode_o = mode_q;
  assign ac_data_o     = ac_data_q;
  assign ac_or_o       = ac_or_q;
  assign ac_clear_o    = ac_clear_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  AST_BIN_FIRST: assert property (
    pop_bin_w && !first_line_seen_ff_q |=>
      tape_word_buffer_q[12:17] == $past(fifo_out_data[5:0])
      && first_line_seen_ff_q && !flag_q)
    else $error("first binary line not in bits 12-17");

  AST_BIN_SHIFT2: assert property (
    pop_bin_w && first_line_seen_ff_q && !second_line_seen_ff_q |=>
      tape_word_buffer_q[6:11] == $past(tape_word_buffer_q[12:17])
      && second_line_seen_ff_q)
    else $error("second binary line shift wrong");

  AST_BIN_SHIFT3: assert property (
    third_w |=>
      tape_word_buffer_q[0:5] == $past(tape_word_buffer_q[6:11])
      && tape_word_buffer_q[6:11] == $past(tape_word_buffer_q[12:17])
      && flag_q ##1 !run_q)
    else $error("third binary line shift or flag wrong");

  AST_NO_HOLE8: assert property (
    pop_w && mode_q && !hole8_w && !clr_any_w |=>
      $stable(tape_word_buffer_q) && $stable(first_line_seen_ff_q)
      && !flag_q)
    else $error("binary line without hole 8 was taken");

  AST_ALPHA_LOAD: assert property (
    hole78_strobe |=>
      tape_word_buffer_q[10:17] == $past(fifo_out_data)
      && tape_word_buffer_q[0:9] == $past(tape_word_buffer_q[0:9])
      && flag_q)
    else $error("alphanumeric line load wrong");

  AST_START: assert property (
    start_w |=> run_q && !flag_q && !first_line_seen_ff_q
      && !second_line_seen_ff_q && tape_word_buffer_q == `PTR_WORD_RST)
    else $error("start pulse did not initialise");

  AST_MODE: assert property (
    start_w |=> mode_q == $past(bin_sel_w || manual_readin_i))
    else $error("mode not taken from instruction");

  AST_CLEAR: assert property (
    clr_any_w && !start_w && !flag_set_w && !manual_readin_i |=>
      !run_q && !mode_q && !flag_q)
    else $error("clear did not reset control");

  AST_STOP: assert property (
    flag_rise_w && !start_w && !manual_readin_i |=> !run_q && !mode_q)
    else $error("flag rise did not stop reader");

  AST_SKIP: assert property (
    skip_o |-> flag_q && skip_on_ready_cmd_i && ready_flag_o)
    else $error("skip without ready flag");

  AST_RCF: assert property (
    clear_flag_or_cmd_i && !rrb_w |=>
      ac_or_o && !ac_clear_o && ac_data_o == $past(tape_word_buffer_q))
    else $error("clear-flag transfer wrong");

  AST_RRB: assert property (
    rrb_w |=> ac_clear_o && ac_or_o
      && ac_data_o == $past(tape_word_buffer_q))
    else $error("read-buffer transfer wrong");

  // Main scenarios
  COV_ALPHA: cover property (start_w && !bin_sel_w ##[1:200] hole78_strobe);
  COV_BIN_WORD: cover property (start_w && bin_sel_w ##[1:600] third_w);
  COV_NO_HOLE8: cover property (pop_w && mode_q && !hole8_w);
  COV_SKIP: cover property (skip_o);
endmodule : ptr_reader_ctrl

// [logic/ptr_defs.svh]
// Purpose: Shared constants of the paper tape reader control.
// Assumes: 200 MHz ref_clk_i; instruction bits indexed from the LSB.
// Notes:   Buffer bits use the big-endian numbering 0 (MSB) to 17 (LSB).
`ifndef PTR_DEFS_SVH
`define PTR_DEFS_SVH
// ****************************************************************
// Widths
// ****************************************************************
`define PTR_WORD_W        18
`define PTR_LINE_W        8
`define PTR_SEG_W         6
`define PTR_FIFO_DEPTH    8
// ****************************************************************
// Field positions
// ****************************************************************
`define PTR_MB_BIN_BIT    5
`define PTR_MB_RRB_BIT    3
`define PTR_HOLE8_BIT     7
// ****************************************************************
// Reset values
// ****************************************************************
`define PTR_WORD_RST      18'h00000
`define PTR_LINE_RST      8'h00
// ****************************************************************
// Timing
// ****************************************************************
`define PTR_CLK_NS        5
`define PTR_SAMPLE_DLY_NS 100000
`define PTR_SAMPLE_DLY_CYC ((`PTR_SAMPLE_DLY_NS + `PTR_CLK_NS - 1) / `PTR_CLK_NS)
`endif

// [logic/ptr_pkg.sv]
// Purpose: Types of the paper tape reader control.
// Assumes: ptr_defs.svh on the include path.
// Notes:   Word type is big-endian to match buffer bit numbering.
`include "ptr_defs.svh"
package ptr_pkg;
  // ****************************************************************
  // Types
  // ****************************************************************
  typedef logic [`PTR_LINE_W-1:0] ptr_line_t;
  typedef logic [0:`PTR_WORD_W-1] ptr_word_t;
  typedef logic [`PTR_WORD_W-1:0] ptr_instr_t;
endpackage : ptr_pkg

// [logic/ptr_fifo.sv]
// Purpose: Small synchronous FIFO for sampled tape lines.
// Assumes: DEPTH is a power of two.
// Notes:   Flush empties the FIFO and wins over push and pop.
`timescale 1ns/10ps
module ptr_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  // ****************************************************************
  // Storage and pointers
  // ****************************************************************
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire           push_w = in_valid_i && in_ready_o;
  wire           pop_w  = out_valid_o && out_ready_i;
  // Handshake terms straight from the count
  assign in_ready_o  = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  // Pointer and count update
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || flush_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push_w) wr_q <= wr_q + 1'b1;
      if (pop_w) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push_w) - (AW+1)'(pop_w);
    end
  end
  // Data array; no reset needed, guarded by count
  always_ff @(posedge ref_clk_i) begin
    if (push_w) mem_q[wr_q] <= in_data_i;
  end
endmodule : ptr_fifo

// [logic/ptr_sample_delay.sv]
// Purpose: Feed-hole delay one-shot producing the sampling strobe.
// Assumes: feed_hole_i synchronous to ref_clk_i, high while hole seen.
// Notes:   Dropping run aborts a pending delay so no stray strobe.
`timescale 1ns/10ps
module ptr_sample_delay #(
  parameter int CYC = 20000
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic feed_hole_i,
  input  wire logic run_i,
  output logic      delayed_sample_pulse_o
);
  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYC - 1);
  logic          feed_prev_q;
  logic          busy_q;
  logic [CW-1:0] cnt_q;
  // Leading edge of the feed hole, only while running
  wire fire_w = feed_hole_i && !feed_prev_q && run_i && !busy_q;
  wire done_w = busy_q && run_i && (cnt_q == '0);
  // ****************************************************************
  // One-shot
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      feed_prev_q            <= 1'b0;
      busy_q                 <= 1'b0;
      cnt_q                  <= '0;
      delayed_sample_pulse_o <= 1'b0;
    end else begin
      feed_prev_q            <= feed_hole_i;
      delayed_sample_pulse_o <= done_w;
      if (fire_w) begin
        busy_q <= 1'b1;
        cnt_q  <= LOAD;
      end else if (busy_q && (!run_i || done_w)) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule : ptr_sample_delay

// [sim/ptr_tape_model.sv]
// Purpose: Behavioural tape reader that feeds lines while the motor runs.
// Assumes: Lines are queued by the bench through the load task.
// Notes:   Data lines toggle while no line is under the heads.
`timescale 1ns/10ps
module ptr_tape_model
  import ptr_pkg::*;
#(
  parameter int DLY = 4
) (
  input  wire logic          ref_clk_i,
  input  wire logic          run_i,
  output logic               feed_hole_o,
  output ptr_pkg::ptr_line_t tape_line_o
);
  import ptr_pkg::*;
  // ****************************************************************
  // Tape contents and speed
  // ****************************************************************
  ptr_line_t lines_q[$];
  int        gap = 2;

  task automatic load(input ptr_line_t l);
    lines_q.push_back(l);
  endtask : load

  // ****************************************************************
  // Tape motion
  // ****************************************************************
  // Hold line and feed hole past the sample point; idle lines toggle
  // so a stale sample never looks like good data
  initial begin
    feed_hole_o = 1'b0;
    tape_line_o = 8'h5A;
    forever begin
      @(posedge ref_clk_i);
      if (run_i && lines_q.size() > 0) begin
        repeat (gap) begin
          @(posedge ref_clk_i);
          tape_line_o <= ~tape_line_o;
        end
        tape_line_o <= lines_q.pop_front();
        feed_hole_o <= 1'b1;
        repeat (DLY + 3) @(posedge ref_clk_i);
        feed_hole_o <= 1'b0;
        tape_line_o <= ~tape_line_o;
      end else begin
        tape_line_o <= ~tape_line_o;
      end
    end
  end
endmodule : ptr_tape_model

// [sim/test_ptr_reader_ctrl.sv]
// Purpose: Self-checking bench of the paper tape reader control.
// Assumes: Short feed delay of 4 cycles; commands are one-cycle pulses.
// Notes:   Buffer readouts are queued expectations checked by a monitor.
`timescale 1ns/10ps
`define PTR_CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module test_ptr_reader_ctrl;
  import ptr_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int DLY = 4;
  typedef struct {ptr_word_t w; logic c;} ptr_tb_exp_s;
  logic         ref_clk_i = 1'b0;
  logic         rst_i     = 1'b1;
  logic         pclr = 1'b0, mbgn = 1'b0, readin = 1'b0;
  logic         skp = 1'b0, clr = 1'b0, sel = 1'b0;
  ptr_instr_t   instr = 18'h00000;
  logic         feed, line_rdy, skip, flag, run, mode, ac_or, ac_clr;
  ptr_line_t    line;
  ptr_word_t    ac_data;
  ptr_tb_exp_s  exp_q[$];
  ptr_tb_exp_s  e;
  logic [7:0]   seed = 8'h61;
  int           fails = 0, total_checks = 0, cyc = 0;

  always #2.5 ref_clk_i = ~ref_clk_i;

  ptr_reader_ctrl #(.SAMPLE_DLY_CYC(DLY), .FIFO_DEPTH(8)) i_ptr_reader_ctrl (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .power_on_clear_i(pclr),
    .manual_begin_pulse_i(mbgn), .manual_readin_i(readin),
    .instruction_holding_reg_i(instr), .skip_on_ready_cmd_i(skp),
    .clear_flag_or_cmd_i(clr), .select_cmd_i(sel), .feed_hole_i(feed),
    .tape_line_i(line), .tape_line_ready_o(line_rdy), .skip_o(skip),
    .ready_flag_o(flag), .reader_run_o(run), .binary_mode_o(mode),
    .ac_data_o(ac_data), .ac_or_o(ac_or), .ac_clear_o(ac_clr));

  ptr_tape_model #(.DLY(DLY)) i_tape (
    .ref_clk_i(ref_clk_i), .run_i(run), .feed_hole_o(feed), .tape_line_o(line));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Stimulus source: 8-bit LFSR, fixed start
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // One-cycle command pulse: 0 select, 1 clear, 2 power clear, 3 begin
  task automatic cmd(input int k, input ptr_instr_t ins);
    @(posedge ref_clk_i);
    instr <= ins;
    sel   <= (k == 0);
    clr   <= (k == 1);
    pclr  <= (k == 2);
    mbgn  <= (k == 3);
    @(posedge ref_clk_i);
    {sel, clr, pclr, mbgn} <= 4'h0;
    #1;
  endtask : cmd

  // Note the expected readout, then issue the clear or read-buffer command
  task automatic read_buf(input logic clr_ac, input ptr_word_t w);
    exp_q.push_back('{w, clr_ac});
    cmd(1, clr_ac ? 18'h3804A : 18'h38042);
    `PTR_CHK(flag, 1'b0)
  endtask : read_buf

  // Skip answer is combinational in the command cycle
  task automatic skip_chk(input logic x);
    @(posedge ref_clk_i);
    instr <= 18'h38041;
    skp   <= 1'b1;
    #1;
    `PTR_CHK(skip, x)
    @(posedge ref_clk_i);
    skp <= 1'b0;
  endtask : skip_chk

  // Wait for completion, then the reader must stop and binary mode must equal mode_after
  task automatic wait_flag(input logic mode_after);
    int n;
    n = 0;
    while (flag !== 1'b1 && n < 300) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    `PTR_CHK(flag, 1'b1)
    @(posedge ref_clk_i);
    #1;
    `PTR_CHK(run, 1'b0)
    `PTR_CHK(mode, mode_after)
  endtask : wait_flag

  // Binary word of three hole-8 lines, optional unpunched junk line
  task automatic bin_word(input logic junk, input logic clr_ac);
    logic [5:0] s[3];
    for (int i = 0; i < 3; i++) begin
      seed = lfsr_next(seed);
      s[i] = seed[5:0];
      if (junk && i == 1) i_tape.load({1'b0, seed[6:0] ^ 7'h2A});
      i_tape.load({1'b1, seed[6], s[i]});
    end
    cmd(0, readin ? 18'h38044 : 18'h38064);
    `PTR_CHK(mode, 1'b1)
    `PTR_CHK(flag, 1'b0)
    wait_flag(readin);
    read_buf(clr_ac, {s[0], s[1], s[2]});
  endtask : bin_word

  // ****************************************************************
  // Monitor and watchdog
  // ****************************************************************
  // Every accumulator transfer consumes the oldest expectation
  always @(posedge ref_clk_i) begin
    if (!rst_i && ac_or === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("BAD t=%0t unexpected transfer", $time);
      end else begin
        e = exp_q.pop_front();
        `PTR_CHK(ac_data, e.w)
        `PTR_CHK(ac_clr, e.c)
      end
    end
  end

  // Ceiling well above the several hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      $display("BAD t=%0t run did not finish", $time);
      give_verdict();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    #1;
    `PTR_CHK({flag, run, mode, ac_or}, 4'h0)
    `PTR_CHK(line_rdy, 1'b1)
    skip_chk(1'b0);
    // Alphanumeric lines, slow and quick tape, both readout kinds
    for (int i = 0; i < 4; i++) begin
      seed = lfsr_next(seed);
      i_tape.gap = (i[0]) ? 9 : 2;
      i_tape.load(seed);
      cmd(0, 18'h38044);
      `PTR_CHK({run, mode, flag}, 3'h4)
      wait_flag(1'b0);
      skip_chk(1'b1);
      read_buf(i[1], {10'h000, seed});
    end
    // Binary words, with a dropped unpunched line in the last two
    for (int i = 0; i < 4; i++) begin
      i_tape.gap = (i[0]) ? 2 : 7;
      bin_word(i[1], i[0]);
    end
    // Every clear source stops a running binary select
    for (int k = 1; k < 4; k++) begin
      cmd(0, 18'h38064);
      `PTR_CHK({run, mode}, 2'h3)
      if (k == 1) exp_q.push_back('{18'h00000, 1'b0});
      cmd(k, 18'h38042);
      `PTR_CHK({run, mode, flag}, 3'h0)
    end
    // Restart in mid-word discards the partial word
    seed = lfsr_next(seed);
    i_tape.load({1'b1, 1'b0, seed[5:0]});
    cmd(0, 18'h38064);
    repeat (25) @(posedge ref_clk_i);
    `PTR_CHK(flag, 1'b0)
    bin_word(1'b0, 1'b1);
    // Manual read-in holds binary mode even for an alphanumeric select
    readin <= 1'b1;
    bin_word(1'b1, 1'b0);
    readin <= 1'b0;
    cmd(2, 18'h00000);
    `PTR_CHK(mode, 1'b0)
    repeat (4) @(posedge ref_clk_i);
    `PTR_CHK(exp_q.size(), 0)
    give_verdict();
  end
endmodule : test_ptr_reader_ctrl
